//--- logic/sdadc_status.sv
// Status flags, result and coefficient holding for a dual sigma-delta converter

// Notes on behaviour
// [R1] Primary ready flag, status bit 7, sets on conversion or calibration completion.
// [R2] Primary ready clears by direct zero write or a calibration mode write.
// [R3] While primary ready is set, primary results and coefficients are frozen.
// [R4] Auxiliary ready flag, bit 6, behaves the same for the auxiliary converter.
// [R5] Calibration-done flag, bit 5, sets when a calibration finishes.
// [R6] Calibration-done clears on any mode write starting conversion or calibration.
// [R7] Auxiliary calibration with temperature sensor selected never completes.
// [R8] Missing-reference flag, bit 4, tracks primary reference fault while converting.
// [R9] With missing reference set, every written result is forced to all ones.
// [R10] Primary error flag, bit 3, sets when the written result was clamped.
// [R11] After calibration, primary error flags a failure that blocked coefficient update.
// [R12] Primary error clears on a mode write starting conversion or calibration.
// [R13] Auxiliary error flag, bit 2, mirrors primary error for the auxiliary converter.
// [R14] Status bits 1 and 0 read zero and ignore writes.
// [R15] Status sits at D8H, resets to 00H, and accepts single-bit writes.
// [R16] Primary result is 24 bits in three bytes; low byte absent on narrow variant.
// [R17] Primary offset coefficient is 24 bits in three bytes.
// [R18] Primary gain coefficient is 24 bits in three bytes.
// [R19] Auxiliary offset and gain coefficients are 16 bits each, two bytes.
// [R20] One decimation word sets the update rate of both converters.
// [R21] Operation codes 100-111 select zero/full-scale internal and system calibrations.
// [R22] Primary power-on bit powers up primary converter; clearing powers it down.
// [R23] Any mode field write clears calibration-done and error flags same cycle; ready flags clear only on a calibration mode write.
module sdadc_status #(
    parameter bit NARROW_RESULT = 1'b0
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Special function register port
    input  wire logic [7:0]  sfr_addr_in,
    input  wire logic        sfr_wr_in,
    input  wire logic [7:0]  sfr_wdata_in,
    input  wire logic        bit_wr_in,
    input  wire logic [2:0]  bit_sel_in,
    input  wire logic        bit_val_in,
    output logic      [7:0]  sfr_rdata_out,
    // Primary converter back end
    input  wire logic        pri_conv_done_in,
    input  wire logic [23:0] pri_raw_in,
    input  wire logic        pri_over_in,
    input  wire logic        pri_under_in,
    input  wire logic        pri_cal_done_in,
    input  wire logic        pri_cal_fail_in,
    input  wire logic [23:0] pri_cal_coeff_in,
    // Auxiliary converter back end
    input  wire logic        aux_conv_done_in,
    input  wire logic [15:0] aux_raw_in,
    input  wire logic        aux_over_in,
    input  wire logic        aux_under_in,
    input  wire logic        aux_cal_done_in,
    input  wire logic        aux_cal_fail_in,
    input  wire logic [15:0] aux_cal_coeff_in,
    input  wire logic        aux_temp_sel_in,
    // Reference detection
    input  wire logic        primary_vref_bad_in,
    // Converter control
    output logic             primary_power_on_out,
    output logic             aux_power_on_out,
    output logic             notch60_out,
    output logic      [2:0]  operation_code_out,
    output logic             mode_write_out,
    output logic      [7:0]  decimation_word_out
);

    // ==============================================
    // Result clamping
    // Returns {clamped, value}; missing reference beats range clamps
    function automatic logic [24:0] clamp24(input logic [23:0] raw, input logic over,
                                            input logic under, input logic noref);
        if (noref || over) begin
            clamp24 = {1'b1, 24'hffffff};
        end else if (under) begin
            clamp24 = {1'b1, 24'h000000};
        end else begin
            clamp24 = {1'b0, raw};
        end
    endfunction

    // Zero-scale codes load offset, full-scale codes load gain
    function automatic logic is_zero_cal(input logic [2:0] op);
        is_zero_cal = (op == sdadc_pkg::OP_INT_ZERO) || (op == sdadc_pkg::OP_SYS_ZERO);
    endfunction

    // ==============================================
    // Registers
    logic        pri_done_r, aux_done_r, cal_done_r, no_vref_r, pri_err_r, aux_err_r;
    logic [6:0]  mode_r;
    logic [7:0]  decim_r;
    logic [23:0] pres_r, poff_r, pgain_r;
    logic [15:0] ares_r, aoff_r, again_r;
    logic [7:0]  rdata_r;

    // ==============================================
    // Decode
    wire         st_wr     = sfr_wr_in && (sfr_addr_in == sdadc_pkg::ADDR_STATUS);
    wire         mode_wr   = sfr_wr_in && (sfr_addr_in == sdadc_pkg::ADDR_MODE);
    wire         decim_wr  = sfr_wr_in && (sfr_addr_in == sdadc_pkg::ADDR_DECIM);
    wire [2:0]   new_op    = sfr_wdata_in[2:0];
    wire         cal_start = mode_wr && new_op[sdadc_pkg::BIT_CAL_MODE];  // R21

    // Status byte after software action, whole byte or single bit
    wire [7:0] status_rd = {pri_done_r, aux_done_r, cal_done_r, no_vref_r,
                            pri_err_r, aux_err_r, 2'b00};                               // R14
    wire [7:0] bit_hit   = bit_wr_in ? (8'h01 << bit_sel_in) : 8'h00;                   // R15
    wire [7:0] st_sw     = st_wr ? sfr_wdata_in : ((status_rd & ~bit_hit) | ({8{bit_val_in}} & bit_hit));

    // Flag values after software action, before hardware events
    wire pri_done_sw = cal_start ? 1'b0 : st_sw[sdadc_pkg::BIT_PRI_DONE];               // R2 R23
    wire aux_done_sw = cal_start ? 1'b0 : st_sw[sdadc_pkg::BIT_AUX_DONE];               // R4 R23
    wire cal_sw      = mode_wr ? 1'b0 : st_sw[sdadc_pkg::BIT_CAL_DONE];                 // R6 R23
    wire pri_err_sw  = mode_wr ? 1'b0 : st_sw[sdadc_pkg::BIT_PRI_CLAMP];                // R12 R23
    wire aux_err_sw  = mode_wr ? 1'b0 : st_sw[sdadc_pkg::BIT_AUX_CLAMP];                // R13 R23

    // Converters may only write while their ready flag is clear (or being cleared)
    wire pri_open = !pri_done_sw;                                                       // R3
    wire aux_open = !aux_done_sw;                                                       // R4

    wire cal_op_zero = is_zero_cal(mode_r[2:0]);                                        // R21

    // Primary events
    wire [24:0] pri_cl     = clamp24(pri_raw_in, pri_over_in, pri_under_in, no_vref_r); // R9
    wire        pri_conv   = pri_conv_done_in && pri_open;
    wire        pri_cal    = pri_cal_done_in && pri_open;
    wire        pri_cal_ok = pri_cal && !pri_cal_fail_in;

    // Auxiliary events; temperature-sensor calibration is dropped
    wire [24:0] aux_cl     = clamp24({aux_raw_in, 8'h00}, aux_over_in, aux_under_in, no_vref_r);  // R9
    wire        aux_conv   = aux_conv_done_in && aux_open;
    wire        aux_cal    = aux_cal_done_in && !aux_temp_sel_in && aux_open;           // R7
    wire        aux_cal_ok = aux_cal && !aux_cal_fail_in;

    wire any_on = mode_r[sdadc_pkg::BIT_PRI_ON] || mode_r[sdadc_pkg::BIT_AUX_ON];

    // ==============================================
    // Flags
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            {pri_done_r, aux_done_r, cal_done_r, no_vref_r, pri_err_r, aux_err_r} <=
                sdadc_pkg::RST_STATUS[7:2];                                             // R15
        end else begin
            pri_done_r <= pri_done_sw || pri_conv || pri_cal;                           // R1
            aux_done_r <= aux_done_sw || aux_conv || aux_cal;                           // R4
            cal_done_r <= cal_sw || pri_cal || aux_cal;                                 // R5 R7
            no_vref_r  <= any_on && primary_vref_bad_in;                                // R8
            pri_err_r  <= pri_err_sw || (pri_conv && pri_cl[24])
                          || (pri_cal && pri_cal_fail_in);                              // R10 R11
            aux_err_r  <= aux_err_sw || (aux_conv && aux_cl[24])
                          || (aux_cal && aux_cal_fail_in);                              // R13
        end
    end

    // ==============================================
    // Mode and decimation
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_r  <= sdadc_pkg::RST_MODE;
            decim_r <= sdadc_pkg::RST_DECIM;
        end else begin
            if (mode_wr) begin
                mode_r <= sfr_wdata_in[6:0];                                            // R22
            end
            if (decim_wr) begin
                decim_r <= sfr_wdata_in;                                                // R20
            end
        end
    end

    // ==============================================
    // Results and coefficients
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pres_r  <= sdadc_pkg::RST_COEFF;
            poff_r  <= sdadc_pkg::RST_COEFF;
            pgain_r <= sdadc_pkg::RST_COEFF;
            ares_r  <= sdadc_pkg::RST_COEFF[15:0];
            aoff_r  <= sdadc_pkg::RST_COEFF[15:0];
            again_r <= sdadc_pkg::RST_COEFF[15:0];
        end else begin
            if (pri_conv) begin
                pres_r <= pri_cl[23:0];                                                 // R16 R3
            end
            if (pri_cal_ok && cal_op_zero) begin
                poff_r <= pri_cal_coeff_in;                                             // R17 R11
            end
            if (pri_cal_ok && !cal_op_zero) begin
                pgain_r <= pri_cal_coeff_in;                                            // R18 R11
            end
            if (aux_conv) begin
                ares_r <= aux_cl[23:8];                                                 // R4
            end
            if (aux_cal_ok && cal_op_zero) begin
                aoff_r <= aux_cal_coeff_in;                                             // R19
            end
            if (aux_cal_ok && !cal_op_zero) begin
                again_r <= aux_cal_coeff_in;                                            // R19
            end
        end
    end

    // ==============================================
    // Read mux, one cycle behind the address
    logic [7:0] rd_sel;
    always_comb begin
        case (sfr_addr_in)
            sdadc_pkg::ADDR_STATUS:  rd_sel = status_rd;
            sdadc_pkg::ADDR_MODE:    rd_sel = {1'b0, mode_r};
            sdadc_pkg::ADDR_DECIM:   rd_sel = decim_r;
            sdadc_pkg::ADDR_PRES_L:  rd_sel = NARROW_RESULT ? 8'h00 : pres_r[7:0];      // R16
            sdadc_pkg::ADDR_PRES_M:  rd_sel = pres_r[15:8];
            sdadc_pkg::ADDR_PRES_H:  rd_sel = pres_r[23:16];
            sdadc_pkg::ADDR_ARES_L:  rd_sel = ares_r[7:0];
            sdadc_pkg::ADDR_ARES_H:  rd_sel = ares_r[15:8];
            sdadc_pkg::ADDR_POFF_L:  rd_sel = NARROW_RESULT ? 8'h00 : poff_r[7:0];
            sdadc_pkg::ADDR_POFF_M:  rd_sel = poff_r[15:8];
            sdadc_pkg::ADDR_POFF_H:  rd_sel = poff_r[23:16];
            sdadc_pkg::ADDR_PGAIN_L: rd_sel = NARROW_RESULT ? 8'h00 : pgain_r[7:0];
            sdadc_pkg::ADDR_PGAIN_M: rd_sel = pgain_r[15:8];
            sdadc_pkg::ADDR_PGAIN_H: rd_sel = pgain_r[23:16];
            sdadc_pkg::ADDR_AOFF_L:  rd_sel = aoff_r[7:0];
            sdadc_pkg::ADDR_AOFF_H:  rd_sel = aoff_r[15:8];
            sdadc_pkg::ADDR_AGAIN_L: rd_sel = again_r[7:0];
            sdadc_pkg::ADDR_AGAIN_H: rd_sel = again_r[15:8];
            default:                 rd_sel = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd_sel;
        end
    end

    // ==============================================
    // Outputs
    assign sfr_rdata_out        = rdata_r;
    assign primary_power_on_out = mode_r[sdadc_pkg::BIT_PRI_ON];                        // R22
    assign aux_power_on_out     = mode_r[sdadc_pkg::BIT_AUX_ON];
    assign notch60_out          = mode_r[sdadc_pkg::BIT_NOTCH60];
    assign operation_code_out   = mode_r[2:0];
    assign mode_write_out       = mode_wr;
    assign decimation_word_out  = decim_r;                                              // R20

endmodule // sdadc_status

//--- include/sdadc_pkg.sv
// Constants for the sigma-delta converter status and result-holding block
package sdadc_pkg;

    // ==============================================
    // Register addresses in special function space
    localparam logic [7:0] ADDR_STATUS    = 8'hd8;
    localparam logic [7:0] ADDR_MODE      = 8'hd1;
    localparam logic [7:0] ADDR_DECIM     = 8'hd4;
    localparam logic [7:0] ADDR_PRES_L    = 8'hd9;
    localparam logic [7:0] ADDR_PRES_M    = 8'hda;
    localparam logic [7:0] ADDR_PRES_H    = 8'hdb;
    localparam logic [7:0] ADDR_ARES_L    = 8'hdc;
    localparam logic [7:0] ADDR_ARES_H    = 8'hdd;
    localparam logic [7:0] ADDR_POFF_L    = 8'he1;
    localparam logic [7:0] ADDR_POFF_M    = 8'he2;
    localparam logic [7:0] ADDR_POFF_H    = 8'he3;
    localparam logic [7:0] ADDR_PGAIN_L   = 8'he9;
    localparam logic [7:0] ADDR_PGAIN_M   = 8'hea;
    localparam logic [7:0] ADDR_PGAIN_H   = 8'heb;
    localparam logic [7:0] ADDR_AOFF_L    = 8'hf1;
    localparam logic [7:0] ADDR_AOFF_H    = 8'hf2;
    localparam logic [7:0] ADDR_AGAIN_L   = 8'hf3;
    localparam logic [7:0] ADDR_AGAIN_H   = 8'hf4;

    // ==============================================
    // Status register bit positions
    localparam int BIT_PRI_DONE  = 7;
    localparam int BIT_AUX_DONE  = 6;
    localparam int BIT_CAL_DONE  = 5;
    localparam int BIT_NO_VREF   = 4;
    localparam int BIT_PRI_CLAMP = 3;
    localparam int BIT_AUX_CLAMP = 2;

    // ==============================================
    // Mode register bit positions
    localparam int BIT_NOTCH60   = 6;
    localparam int BIT_PRI_ON    = 5;
    localparam int BIT_AUX_ON    = 4;
    localparam int BIT_CAL_MODE  = 2;

    // ==============================================
    // Reset values
    localparam logic [7:0]  RST_STATUS = 8'h00;
    localparam logic [6:0]  RST_MODE   = 7'h08;
    localparam logic [7:0]  RST_DECIM  = 8'h45;
    localparam logic [23:0] RST_COEFF  = 24'h000000;

    // ==============================================
    // Calibration operation codes
    localparam logic [2:0] OP_INT_ZERO = 3'h4;
    localparam logic [2:0] OP_INT_FULL = 3'h5;
    localparam logic [2:0] OP_SYS_ZERO = 3'h6;
    localparam logic [2:0] OP_SYS_FULL = 3'h7;

endpackage

//--- sim/sdadc_props.sv
// Concurrent checks on the ports of the converter status block
module sdadc_status_props (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic [7:0]  sfr_addr_in,
    input wire logic        sfr_wr_in,
    input wire logic [7:0]  sfr_wdata_in,
    input wire logic        bit_wr_in,
    input wire logic [7:0]  sfr_rdata_out,
    input wire logic        pri_conv_done_in,
    input wire logic        pri_cal_done_in,
    input wire logic        aux_conv_done_in,
    input wire logic        aux_cal_done_in,
    input wire logic        primary_vref_bad_in,
    input wire logic        primary_power_on_out,
    input wire logic        aux_power_on_out,
    input wire logic [2:0]  operation_code_out,
    input wire logic        mode_write_out,
    input wire logic [7:0]  decimation_word_out
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic st_sel = sfr_addr_in == sdadc_pkg::ADDR_STATUS;
    wire logic md_wr  = sfr_wr_in && sfr_addr_in == sdadc_pkg::ADDR_MODE;
    wire logic no_ev  = !(pri_conv_done_in || pri_cal_done_in || aux_conv_done_in || aux_cal_done_in);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ==============================================
    // Flags seen through a status read one cycle later
    pri_ready_a: assert property (pri_conv_done_in && !sfr_wr_in && !bit_wr_in ##1 st_sel |=> sfr_rdata_out[7])
        else $error("primary ready flag not set after a conversion");
    aux_ready_a: assert property (aux_conv_done_in && !sfr_wr_in && !bit_wr_in ##1 st_sel |=> sfr_rdata_out[6])
        else $error("aux ready flag not set after a conversion");
    unused_bits_a: assert property ($past(st_sel) |-> sfr_rdata_out[1:0] == 2'h0)
        else $error("unused status bits read nonzero");
    flag_clear_a: assert property (md_wr && no_ev && !bit_wr_in ##1 st_sel |=> !sfr_rdata_out[5] && sfr_rdata_out[3:2] == 2'h0)
        else $error("mode write left calibration or error flags set");
    vref_flag_a: assert property ((primary_power_on_out || aux_power_on_out) && primary_vref_bad_in ##1 st_sel |=> sfr_rdata_out[4])
        else $error("missing reference flag not set");
    // ==============================================
    // Control outputs
    mode_strobe_a: assert property (mode_write_out == md_wr)
        else $error("mode write strobe wrong");
    power_on_a: assert property (md_wr |=> primary_power_on_out == $past(sfr_wdata_in[5]) && aux_power_on_out == $past(sfr_wdata_in[4]) && operation_code_out == $past(sfr_wdata_in[2:0]))
        else $error("mode outputs do not follow the written mode");
    decim_word_a: assert property (sfr_wr_in && sfr_addr_in == sdadc_pkg::ADDR_DECIM |=> decimation_word_out == $past(sfr_wdata_in))
        else $error("decimation word not taken");
    cover property (pri_cal_done_in);
    cover property (md_wr);
    cover property (primary_vref_bad_in && primary_power_on_out);
endmodule // sdadc_status_props

bind sdadc_status sdadc_status_props u_props (.*);

//--- sim/sdadc_core_model.sv
// Core-side model driving the special function register port
module sdadc_core_model (
    input  wire logic       clk_in,
    output logic      [7:0] addr_out,
    output logic            wr_out,
    output logic      [7:0] wdata_out,
    output logic            bwr_out,
    output logic      [2:0] bsel_out,
    output logic            bval_out,
    output logic            rd_vld_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {addr_out, wdata_out, wr_out, bwr_out, rd_vld_out} = {sdadc_pkg::ADDR_STATUS, 11'h0};
        {bsel_out, bval_out} = 4'h0;
    end
    // Hold one edge, release with inverted data, then one idle edge; idle address parks on status
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w, input logic b, input logic r);
        {addr_out, wdata_out, wr_out, bwr_out, rd_vld_out} = {a, d, w, b, r};
        {bsel_out, bval_out} = {d[2:0], d[3]};
        @(posedge clk_in);
        #1;
        {addr_out, wdata_out, wr_out, bwr_out, rd_vld_out} = {sdadc_pkg::ADDR_STATUS, ~d, 3'b000};
        {bsel_out, bval_out} = ~{d[2:0], d[3]};
        @(posedge clk_in);
        #1;
    endtask
endmodule // sdadc_core_model

//--- sim/sdadc_status_tb_top.sv
// Self-checking testbench for the converter status block
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module sdadc_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, rd_vld, rd_vld_d = 1'b0;
    logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out, decimation_word_out, e;
    logic        sfr_wr_in, bit_wr_in, bit_val_in, primary_power_on_out, aux_power_on_out, notch60_out, mode_write_out;
    logic [2:0]  bit_sel_in, operation_code_out;
    logic        pri_conv_done_in, pri_over_in, pri_under_in, pri_cal_done_in, pri_cal_fail_in;
    logic        aux_conv_done_in, aux_over_in, aux_under_in, aux_cal_done_in, aux_cal_fail_in;
    logic        aux_temp_sel_in, primary_vref_bad_in;
    logic [23:0] pri_raw_in, pri_cal_coeff_in, v;
    logic [15:0] aux_raw_in, aux_cal_coeff_in;
    logic [7:0]  exp_q[$];
    string       nm_q[$], nm;
    int          n_errors = 0, compares = 0;
    localparam logic [7:0] ST = sdadc_pkg::ADDR_STATUS;
    sdadc_status DUT (.*);
    sdadc_core_model core (.clk_in(clk_in), .addr_out(sfr_addr_in), .wr_out(sfr_wr_in), .wdata_out(sfr_wdata_in),
        .bwr_out(bit_wr_in), .bsel_out(bit_sel_in), .bval_out(bit_val_in), .rd_vld_out(rd_vld));
    initial forever #2 clk_in = ~clk_in;
    // ==============================================
    // Read results one cycle after the address edge
    always @(posedge clk_in) begin
        if (rd_vld_d) begin
            e = exp_q.pop_front();
            nm = nm_q.pop_front();
            `CHK(nm, e, sfr_rdata_out)
        end
        rd_vld_d <= rd_vld;
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input string n);
        exp_q.push_back(x);
        nm_q.push_back(n);
        core.xfer(a, 8'h00, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core.xfer(a, d, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clk_in);
        #1 s = 1'b0;
    endtask
    task automatic pconv(input logic [23:0] r, input logic [1:0] ou);
        {pri_raw_in, pri_over_in, pri_under_in} = {r, ou};
        pulse(pri_conv_done_in);
    endtask
    task automatic pcal(input logic [23:0] c, input logic f);
        {pri_cal_coeff_in, pri_cal_fail_in} = {c, f};
        pulse(pri_cal_done_in);
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==============================================
    // Watchdog, far beyond the roughly 130 cycles the tests need
    initial begin
        #20000;
        n_errors++;
        summarize();
    end
    initial begin
        logic [7:0] za[7];
        za = '{ST, sdadc_pkg::ADDR_PRES_H, sdadc_pkg::ADDR_POFF_H, sdadc_pkg::ADDR_PGAIN_L,
               sdadc_pkg::ADDR_AOFF_L, sdadc_pkg::ADDR_AGAIN_H, 8'h80};
        {pri_conv_done_in, pri_over_in, pri_under_in, pri_cal_done_in, pri_cal_fail_in, aux_conv_done_in,
         aux_over_in, aux_under_in, aux_cal_done_in, aux_cal_fail_in, aux_temp_sel_in, primary_vref_bad_in} = '0;
        {pri_raw_in, pri_cal_coeff_in, aux_raw_in, aux_cal_coeff_in} = '0;
        void'($urandom(32'hcfed));
        repeat (3) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        foreach (za[i]) rd(za[i], 8'h00, "reset value");
        rd(sdadc_pkg::ADDR_DECIM, sdadc_pkg::RST_DECIM, "decimation reset");
        $display("test reset done");
        v = 24'($urandom);
        pconv(v, 2'b00);
        rd(ST, 8'h80, "ready after conversion");
        pconv(~v, 2'b00);
        rd(sdadc_pkg::ADDR_PRES_H, v[23:16], "held result high");
        rd(sdadc_pkg::ADDR_PRES_M, v[15:8], "held result mid");
        rd(sdadc_pkg::ADDR_PRES_L, v[7:0], "held result low");
        core.xfer(ST, 8'h07, 1'b0, 1'b1, 1'b0);
        core.xfer(ST, 8'h09, 1'b0, 1'b1, 1'b0);
        core.xfer(ST, 8'h0c, 1'b0, 1'b1, 1'b0);
        rd(ST, 8'h00, "status after bit writes");
        {aux_raw_in, aux_over_in} = {16'($urandom), 1'b1};
        pulse(aux_conv_done_in);
        aux_over_in = 1'b0;
        rd(ST, 8'h44, "aux over-range flags");
        rd(sdadc_pkg::ADDR_ARES_H, 8'hff, "aux clamped result");
        $display("test conversion done");
        for (int op = 4; op < 8; op++) begin
            v = 24'($urandom);
            wr(sdadc_pkg::ADDR_MODE, 8'h20 | 8'(op));
            rd(ST, 8'h00, "flags after mode write");
            pcal(v, 1'b0);
            rd(ST, 8'ha0, "calibration done");
            rd(op[0] ? sdadc_pkg::ADDR_PGAIN_H : sdadc_pkg::ADDR_POFF_H, v[23:16], "coefficient");
        end
        wr(sdadc_pkg::ADDR_MODE, 8'h25);
        pcal(~v, 1'b1);
        rd(ST, 8'ha8, "calibration failure");
        rd(sdadc_pkg::ADDR_PGAIN_H, v[23:16], "gain kept on failure");
        wr(sdadc_pkg::ADDR_MODE, 8'h14);
        {aux_temp_sel_in, aux_cal_coeff_in, aux_cal_fail_in} = {1'b1, 16'($urandom), 1'b0};
        pulse(aux_cal_done_in);
        rd(ST, 8'h00, "temperature calibration");
        rd(sdadc_pkg::ADDR_AOFF_L, 8'h00, "aux offset untouched");
        aux_temp_sel_in = 1'b0;
        pulse(aux_cal_done_in);
        rd(ST, 8'h60, "aux calibration done");
        rd(sdadc_pkg::ADDR_AOFF_H, aux_cal_coeff_in[15:8], "aux offset");
        $display("test calibration done");
        wr(sdadc_pkg::ADDR_MODE, 8'h20);
        primary_vref_bad_in = 1'b1;
        @(posedge clk_in);
        #1;
        rd(ST, 8'h50, "missing reference");
        pconv(v, 2'b00);
        rd(ST, 8'hd8, "clamped result flags");
        rd(sdadc_pkg::ADDR_PRES_M, 8'hff, "clamped result");
        primary_vref_bad_in = 1'b0;
        wr(sdadc_pkg::ADDR_MODE, 8'h24);
        pconv(v, 2'b01);
        rd(ST, 8'h88, "under-range flags");
        rd(sdadc_pkg::ADDR_PRES_H, 8'h00, "under-range result");
        $display("test reference done");
        wr(sdadc_pkg::ADDR_DECIM, v[7:0]);
        rd(sdadc_pkg::ADDR_DECIM, v[7:0], "decimation word");
        `CHK("decimation output", v[7:0], decimation_word_out)
        wr(ST, 8'hff);
        rd(ST, 8'hec, "status byte write");
        wr(sdadc_pkg::ADDR_PRES_H, 8'h5a);
        rd(sdadc_pkg::ADDR_PRES_H, 8'h00, "result not writable");
        wr(sdadc_pkg::ADDR_MODE, 8'h74);
        rd(sdadc_pkg::ADDR_MODE, 8'h74, "mode readback");
        `CHK("mode outputs", 6'h3c, {notch60_out, primary_power_on_out, aux_power_on_out, operation_code_out})
        $display("test registers done");
        summarize();
    end
endmodule // sdadc_status_tb_top
